// ---- hdl/topc_pkg.sv ----
/*
  Shared constants, types and helpers of the timed output port controller.
  Assumes the core clock period given below; the internal short unit cycle counts derive from it.
*/
package topc_pkg;

  // Core clock and scale units
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned SHORT_A_NS     = 5000;
  localparam int unsigned SHORT_B_NS     = 10000;
  localparam int unsigned SHORT_A_CYC    =
    (SHORT_A_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_B_CYC    =
    (SHORT_B_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_A_EDGES    = 1;
  localparam int unsigned EXT_B_EDGES    = 2;
  localparam int unsigned LONG_PER_SHORT = 64;

  // Command codes
  localparam logic [3:0] CMD_RELOAD = 4'h0;
  localparam logic [3:0] CMD_ACCESS = 4'h1;
  localparam logic [3:0] CMD_TSTART = 4'h2;
  localparam logic [3:0] CMD_LEVEL  = 4'h5;
  localparam logic [3:0] CMD_SCALE  = 4'h6;
  localparam logic [3:0] CMD_PDLY0  = 4'h8;
  localparam logic [3:0] CMD_PDLY3  = 4'hB;

  // Reloadable register slots and values
  localparam int unsigned NREG         = 6;
  localparam logic [2:0]  IDX_LEVEL    = 3'h0;
  localparam logic [2:0]  IDX_SCALE    = 3'h1;
  localparam logic [2:0]  IDX_PDLY0    = 3'h2;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [7:0]  NVM_RESET    = 8'h00;
  localparam logic [7:0]  TSTART_RDVAL = 8'hFF;

  // Serial framing
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;

  // Synchroniser lanes
  localparam int unsigned SY_TOG  = 0;
  localparam int unsigned SY_SCL  = 1;
  localparam int unsigned SY_SDA  = 2;
  localparam int unsigned SY_GATE = 3;
  localparam int unsigned SY_EXT  = 4;
  localparam int unsigned SY_LVD  = 5;
  localparam int unsigned SY_N    = 6;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WR, ST_RD, ST_SKIP}
    topc_state_e;

  // Lowest set bit n gives multiple n+1; no bit gives zero
  function automatic logic [3:0] topc_mult(input logic [7:0] onehot);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (onehot[i]) begin
        m = 4'(i + 1);
      end
    end
    return m;
  endfunction

  function automatic logic topc_is_reg(input logic [3:0] cmd);
    return (cmd == CMD_LEVEL) || (cmd == CMD_SCALE) ||
           ((cmd >= CMD_PDLY0) && (cmd <= CMD_PDLY3));
  endfunction

  function automatic logic [2:0] topc_reg_index(input logic [3:0] cmd);
    logic [2:0] idx;
    idx = IDX_LEVEL;
    if (cmd == CMD_SCALE) begin
      idx = IDX_SCALE;
    end else if (cmd >= CMD_PDLY0) begin
      idx = IDX_PDLY0 + {1'b0, cmd[1:0]};
    end
    return idx;
  endfunction

endpackage

// ---- hdl/topc_tick_if.sv ----
/*
  Scale tick carrier between the tick generator and the port timers.
  Assumes all members live in the core clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
interface topc_tick_if;
  logic run;
  logic short_tick;
  logic long_tick;
  modport src (input run, output short_tick, output long_tick);
  modport dst (input short_tick, input long_tick);
endinterface
`default_nettype wire

// ---- hdl/topc_tick_gen.sv ----
/*
  Scale tick generator: short unit ticks and long unit ticks (64 shorts).
  Assumes ext_rise_i is a one-cycle pulse already synchronised to core_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none
module topc_tick_gen
  import topc_pkg::*;
#(
  parameter bit OPTION_B  = 1'b0,
  parameter bit EXT_CLOCK = 1'b0
) (
  // Clock and reset
  input  wire logic   core_clk_i,
  input  wire logic   arst_n_i,
  // External clock edge
  input  wire logic   ext_rise_i,
  // Tick carrier
  topc_tick_if.src    tick
);

  localparam int unsigned SHORT_LEN = EXT_CLOCK ?
    (OPTION_B ? EXT_B_EDGES : EXT_A_EDGES) :
    (OPTION_B ? SHORT_B_CYC : SHORT_A_CYC);

  logic [7:0] base_reg;
  logic [5:0] long_reg;
  logic       short_reg;
  logic       longt_reg;

  wire step      = EXT_CLOCK ? ext_rise_i : 1'b1;
  wire base_wrap = step && (base_reg == 8'(SHORT_LEN - 1));
  wire long_wrap = base_wrap && (long_reg == 6'(LONG_PER_SHORT - 1));

  // Counters held at zero while stopped so a start aligns the phase
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      base_reg  <= 8'h00;
      long_reg  <= 6'h00;
      short_reg <= 1'b0;
      longt_reg <= 1'b0;
    end else if (!tick.run) begin
      base_reg  <= 8'h00;
      long_reg  <= 6'h00;
      short_reg <= 1'b0;
      longt_reg <= 1'b0;
    end else begin
      base_reg  <= base_wrap ? 8'h00 : (step ? base_reg + 8'h01 : base_reg);
      long_reg  <= base_wrap ? long_reg + 6'h01 : long_reg;
      short_reg <= base_wrap;
      longt_reg <= long_wrap;
    end
  end

  assign tick.short_tick = short_reg;
  assign tick.long_tick  = longt_reg;

  chk_tick_idle: assert property (
    @(posedge core_clk_i) disable iff (!arst_n_i)
    !tick.run |=> !tick.short_tick && !tick.long_tick)
    else $error("scale tick while oscillator stopped");

endmodule
`default_nettype wire

// ---- hdl/topc_port_timer.sv ----
/*
  Delay counter of one lower output port: counts scale units after a start
  and pulses fire_o once the programmed multiple has elapsed.
  Assumes ticks from topc_tick_gen on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module topc_port_timer
  import topc_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  // Control
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic       short_scale_i,
  input  wire logic [3:0] mult_i,
  // Ticks
  topc_tick_if.dst        tick,
  // Status
  output logic            armed_o,
  output logic            fire_o
);

  logic       armed_reg;
  logic       scale_reg;
  logic       fire_reg;
  logic [3:0] cnt_reg;
  logic [3:0] mult_reg;

  wire unit = scale_reg ? tick.short_tick : tick.long_tick;
  wire last = unit && ((cnt_reg + 4'h1) == mult_reg);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_reg <= 1'b0;
      scale_reg <= 1'b0;
      fire_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      mult_reg  <= 4'h0;
    end else begin
      fire_reg <= 1'b0;
      if (abort_i) begin
        armed_reg <= 1'b0;
      end else if (!armed_reg && start_i && mult_i != 4'h0) begin
        armed_reg <= 1'b1;
        scale_reg <= short_scale_i;
        cnt_reg   <= 4'h0;
        mult_reg  <= mult_i;
      end else if (armed_reg && unit) begin
        armed_reg <= !last;
        fire_reg  <= last;
        cnt_reg   <= cnt_reg + 4'h1;
      end
    end
  end

  assign armed_o = armed_reg;
  assign fire_o  = fire_reg;

  chk_fire_after_count: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i)
    fire_o |-> $past(armed_reg) && $past(cnt_reg) + 4'h1 == $past(mult_reg))
    else $error("port fired before its multiple elapsed");

endmodule
`default_nettype wire

// ---- hdl/topc_controller.sv ----
/*
  Timed output port controller: serial command decoder, reloadable working
  registers with nonvolatile copies, timer start logic and output drive.
  Assumes scl_clk_i and scl_i are the same serial clock pin, the one as a
  clock and the other as a level; sda is open drain, resolved outside.
*/
// Notes on behaviour
// - reload copies nonvolatile values, any R/W bit
// - reload ignored while a timer action runs
// - access command R/W 0 register, 1 nonvolatile
// - register mode writes working copy only
// - timer start mask write-only, reads FFh
// - start bit runs oscillator, port inverts later
// - timer action begins at the received LSB
// - timer start bits clear themselves
// - timer start writes rejected while running
// - level bits drive eight outputs high/low
// - inversion leaves stored level bits unchanged
// - scale bit 1 short unit, 0 long
// - upper scale bits plain reloaded storage
// - one-hot multiple 1 to 8; zero disables
// - internal units 5/320 us or 10/640 us
// - external units T'/64T' or 2T'/128T'
// - option 1 starts on reload, gate edge, write
// - option 2 starts only on start-bit write
// - power-up and supply release reload, maybe start
// - started action ignores gate falling low
// - oscillator runs only during timer action
// - low supply clears logic, outputs low; reload after
// - first byte holds device code, command, R/W
// - reads return the selected access copy
`timescale 1ns/1ns
`default_nettype none
module topc_controller
  import topc_pkg::*;
#(
  parameter logic [2:0] DEV_CODE     = 3'h0,
  parameter int         START_OPTION = 1,
  parameter bit         OPTION_B     = 1'b0,
  parameter bit         EXT_CLOCK    = 1'b0
) (
  // Clocks and reset
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       scl_clk_i,
  // Serial bus pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Timer and supply pins
  input  wire logic       start_gate_pin_i,
  input  wire logic       ext_clk_i,
  input  wire logic       low_volt_i,
  // Outputs and status
  output logic [7:0]      port_out_o,
  output logic            osc_run_o
);

  // Link side: capture each bit on the serial clock, flag it by a toggle
  logic link_bit_reg;
  logic link_tog_reg;

  always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      link_bit_reg <= 1'b0;
      link_tog_reg <= 1'b0;
    end else begin
      link_bit_reg <= sda_i;
      link_tog_reg <= ~link_tog_reg;
    end
  end

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [SY_N-1:0] sy1_reg;
  logic [SY_N-1:0] sy2_reg;
  logic [SY_N-1:0] sy3_reg;
  logic [SY_N-1:0] filt_reg;
  logic [SY_N-1:0] prev_reg;

  wire [SY_N-1:0] sy_raw  = {low_volt_i, ext_clk_i, start_gate_pin_i,
                             sda_i, scl_i, link_tog_reg};
  wire [SY_N-1:0] sy_diff = sy2_reg ^ sy3_reg;
  wire [SY_N-1:0] filt_next = (sy2_reg & ~sy_diff) | (filt_reg & sy_diff);

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sy1_reg  <= '0;
      sy2_reg  <= '0;
      sy3_reg  <= '0;
      filt_reg <= '0;
      prev_reg <= '0;
    end else begin
      sy1_reg  <= sy_raw;
      sy2_reg  <= sy1_reg;
      sy3_reg  <= sy2_reg;
      filt_reg <= filt_next;
      prev_reg <= filt_reg;
    end
  end

  wire tog_evt   = filt_reg[SY_TOG] ^ prev_reg[SY_TOG];
  wire scl_hold  = filt_reg[SY_SCL] & prev_reg[SY_SCL];
  wire scl_fall  = prev_reg[SY_SCL] & ~filt_reg[SY_SCL];
  wire bus_start = scl_hold & prev_reg[SY_SDA] & ~filt_reg[SY_SDA];
  wire bus_stop  = scl_hold & ~prev_reg[SY_SDA] & filt_reg[SY_SDA];
  wire gate      = filt_reg[SY_GATE];
  wire gate_rise = gate & ~prev_reg[SY_GATE];
  wire ext_rise  = filt_reg[SY_EXT] & ~prev_reg[SY_EXT];
  wire lvd       = filt_reg[SY_LVD];

  // Frame decoder state
  topc_state_e state_reg;
  logic [3:0]  bitcnt_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  cmd_reg;
  logic        rw_reg;
  logic [7:0]  tx_reg;
  logic        ack_pend_reg;
  logic        oe_reg;

  // Working and nonvolatile copies, timer state
  logic [7:0]  wreg_reg [NREG];
  logic [7:0]  nvm_reg  [NREG];
  logic        nvm_mode_reg;
  logic        reload_req_reg;
  logic        reload_done_reg;
  logic [3:0]  inv_reg;
  logic [7:0]  port_out_reg;
  logic        osc_run_reg;
  logic [3:0]  armed;
  logic [3:0]  fire;

  wire active    = (state_reg != ST_IDLE);
  wire byte_done = tog_evt && active && (bitcnt_reg == BYTE_LAST_BIT);
  wire [7:0] rx_byte = {shift_reg[6:0], link_bit_reg};
  wire addr_done  = byte_done && (state_reg == ST_ADDR);
  wire addr_match = (rx_byte[7:5] == DEV_CODE);
  wire [3:0] new_cmd = rx_byte[4:1];
  wire new_rw     = rx_byte[0];
  wire one_byte   = (new_cmd == CMD_RELOAD) || (new_cmd == CMD_ACCESS);
  wire wr_done    = byte_done && (state_reg == ST_WR);
  wire busy       = |armed;
  wire [2:0] reg_idx = topc_reg_index(cmd_reg);
  wire [2:0] new_idx = topc_reg_index(new_cmd);

  wire reg_write    = wr_done && topc_is_reg(cmd_reg) && !lvd;
  wire tstart_write = wr_done && (cmd_reg == CMD_TSTART) && !busy
                      && !lvd;
  wire reload_cmd   = addr_done && addr_match && (new_cmd == CMD_RELOAD)
                      && !busy;
  wire access_cmd   = addr_done && addr_match && (new_cmd == CMD_ACCESS);
  wire reload_go    = reload_req_reg && !lvd && !busy;
  wire want_ack     = (addr_done && addr_match) || wr_done ||
                      (byte_done && state_reg == ST_SKIP && !rw_reg);
  wire tx_bit       = tx_reg[~bitcnt_reg[2:0]];

  wire [7:0] rd_value = (new_cmd == CMD_TSTART) ? TSTART_RDVAL :
                        !topc_is_reg(new_cmd) ? REG_RESET :
                        nvm_mode_reg ? nvm_reg[new_idx] :
                        wreg_reg[new_idx];

  topc_state_e addr_next;
  assign addr_next = !addr_match ? ST_IDLE :
                     one_byte    ? ST_SKIP :
                     new_rw      ? ST_RD   : ST_WR;

  // Frame sequencing: start resets it, stop ends it, bytes advance it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg  <= ST_IDLE;
      bitcnt_reg <= 4'h0;
      shift_reg  <= 8'h00;
    end else if (lvd || bus_stop) begin
      state_reg  <= ST_IDLE;
    end else if (bus_start) begin
      state_reg  <= ST_ADDR;
      bitcnt_reg <= 4'h0;
    end else if (tog_evt && active) begin
      bitcnt_reg <= (bitcnt_reg == ACK_SLOT) ? 4'h0 : bitcnt_reg + 4'h1;
      if (bitcnt_reg != ACK_SLOT) begin
        shift_reg <= rx_byte;
      end
      if (addr_done) begin
        state_reg <= addr_next;
      end else if (byte_done) begin
        state_reg <= ST_SKIP;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_reg <= 4'h0;
      rw_reg  <= 1'b0;
      tx_reg  <= 8'h00;
    end else if (addr_done && addr_match) begin
      cmd_reg <= new_cmd;
      rw_reg  <= new_rw;
      tx_reg  <= rd_value;
    end
  end

  // Open-drain data: acknowledge low, then read bits MSB first on SCL fall
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_pend_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else if (lvd || bus_start || bus_stop) begin
      ack_pend_reg <= 1'b0;
      oe_reg       <= 1'b0;
    end else if (want_ack) begin
      ack_pend_reg <= 1'b1;
    end else if (scl_fall) begin
      ack_pend_reg <= 1'b0;
      oe_reg       <= ack_pend_reg ||
                      (state_reg == ST_RD && bitcnt_reg < ACK_SLOT && !tx_bit);
    end
  end

  // Working copies: cleared by low supply, loaded by reload or write
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        wreg_reg[i] <= REG_RESET;
      end
    end else if (lvd) begin
      for (int i = 0; i < NREG; i++) begin
        wreg_reg[i] <= REG_RESET;
      end
    end else if (reload_go) begin
      for (int i = 0; i < NREG; i++) begin
        wreg_reg[i] <= nvm_reg[i];
      end
    end else if (reg_write) begin
      wreg_reg[reg_idx] <= rx_byte;
    end
  end

  // Nonvolatile copies change only on writes in nonvolatile mode
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < NREG; i++) begin
        nvm_reg[i] <= NVM_RESET;
      end
    end else if (reg_write && nvm_mode_reg) begin
      nvm_reg[reg_idx] <= rx_byte;
    end
  end

  // Power-up and supply release both leave a reload pending
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nvm_mode_reg    <= 1'b0;
      reload_req_reg  <= 1'b1;
      reload_done_reg <= 1'b0;
    end else begin
      nvm_mode_reg    <= lvd ? 1'b0 :
                         access_cmd ? new_rw : nvm_mode_reg;
      reload_req_reg  <= lvd || reload_cmd ||
                         (reload_req_reg && !reload_go);
      reload_done_reg <= reload_go;
    end
  end

  // Timer start: start-bit writes are one-cycle strobes at the LSB
  wire [3:0] tstart_mask = tstart_write ? rx_byte[3:0] : 4'h0;
  wire       start_all   = (reload_done_reg || gate_rise) && gate;
  wire [3:0] opt1_vec    = {4{start_all}} | (tstart_mask & {4{gate}});
  wire [3:0] start_vec   = (busy || lvd) ? 4'h0 :
                           (START_OPTION == 1) ? opt1_vec :
                           tstart_mask;

  topc_tick_if tick_bus ();

  assign tick_bus.run = busy;

  topc_tick_gen #(
    .OPTION_B  (OPTION_B),
    .EXT_CLOCK (EXT_CLOCK)
  ) u_tick (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .ext_rise_i (ext_rise),
    .tick       (tick_bus)
  );

  // Only a low supply aborts; a falling gate does not
  for (genvar g = 0; g < 4; g++) begin : g_port
    topc_port_timer u_port (
      .core_clk_i    (core_clk_i),
      .arst_n_i      (arst_n_i),
      .start_i       (start_vec[g]),
      .abort_i       (lvd),
      .short_scale_i (wreg_reg[IDX_SCALE][g]),
      .mult_i        (topc_mult(wreg_reg[IDX_PDLY0 + g])),
      .tick          (tick_bus),
      .armed_o       (armed[g]),
      .fire_o        (fire[g])
    );
  end

  // Inversion sits beside the level bits, never inside them
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      inv_reg      <= 4'h0;
      port_out_reg <= 8'h00;
      osc_run_reg  <= 1'b0;
    end else begin
      inv_reg      <= lvd ? 4'h0 : (inv_reg ^ fire);
      port_out_reg <= lvd ? 8'h00 :
                      (wreg_reg[IDX_LEVEL] ^ {4'h0, inv_reg});
      osc_run_reg  <= busy;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_o   = oe_reg;
  assign port_out_o = port_out_reg;
  assign osc_run_o  = osc_run_reg;

  logic [8*NREG-1:0] nvm_flat;
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      nvm_flat[8*i +: 8] = nvm_reg[i];
    end
  end

  chk_tstart_rdval: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) (addr_done && addr_match && new_rw &&
    new_cmd == CMD_TSTART) |=> tx_reg == TSTART_RDVAL)
    else $error("timer start mask did not read FFh");

  chk_reload_idle: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) busy |=> !reload_done_reg)
    else $error("reload completed during a timer action");

  chk_tstart_reject: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) (busy && wr_done && cmd_reg == CMD_TSTART)
    |=> (armed & ~$past(armed)) == 4'h0)
    else $error("timer start accepted while running");

  chk_mode_select: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) (access_cmd && !lvd)
    |=> nvm_mode_reg == $past(new_rw))
    else $error("access mode not taken from R/W bit");

  chk_nvm_kept: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) (reg_write && !nvm_mode_reg)
    |=> $stable(nvm_flat))
    else $error("register mode write changed nonvolatile copy");

  chk_level_kept: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) (|fire && !reg_write && !reload_go && !lvd)
    |=> $stable(wreg_reg[IDX_LEVEL]))
    else $error("inversion altered the level bits");

  chk_upper_follow: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) !lvd ##1 !lvd
    |-> port_out_o[7:4] == $past(wreg_reg[IDX_LEVEL][7:4]))
    else $error("upper outputs differ from level bits");

  chk_lvd_outputs: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) lvd |=> port_out_o == 8'h00)
    else $error("outputs not low under low supply");

  chk_osc_stop: assert property (@(posedge core_clk_i)
    disable iff (!arst_n_i) !busy |=> !osc_run_o)
    else $error("oscillator running with no timer action");

endmodule
`default_nettype wire

// ---- verification/topc_host_model.sv ----
/* Serial master model: start, bytes with ack slots, stop.
   Assumes SDA pulled up and resolved by the bench. */
`timescale 1ns/1ns
`default_nettype none
module topc_host_model (
  // Clock
  input  wire logic core_clk_i,
  // Bus
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // SCL low 1.4 us, high 0.8 us; SDA moves only while SCL is low
  task automatic bit_io(input logic b, output logic r);
    scl_o <= 1'b0;
    w(2);
    sda_o <= b;
    w(12);
    scl_o <= 1'b1;
    w(8);
    r = sda_i;
  endtask

  task automatic frame(input logic [7:0] a, input logic [7:0] d,
                       input int nb, output logic [7:0] rd,
                       output logic ok);
    logic       r;
    logic [7:0] by;
    ok = 1'b1;
    rd = 8'h00;
    w(8);
    sda_o <= 1'b0;
    w(8);
    for (int i = 0; i < nb; i++) begin
      by = (i == 0) ? a : d;
      for (int k = 7; k >= 0; k--) begin
        bit_io(by[k], r);
        rd[k] = r;
      end
      bit_io(1'b1, r);
      if (i == 0 || !a[0]) begin
        ok = ok & ~r;
      end
    end
    scl_o <= 1'b0;
    w(2);
    sda_o <= 1'b0;
    w(12);
    scl_o <= 1'b1;
    w(8);
    sda_o <= 1'b1;
    w(14);
  endtask
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
/* Self-checking bench of the timed output port controller.
   Assumes topc_host_model as serial master and a pull-up on SDA. */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import topc_pkg::*;
;
  typedef struct packed {
    logic [3:0] c;
    logic [7:0] d;
    logic [7:0] e;
  } topc_row_s;
  localparam logic [2:0] DEV = 3'h5;
  localparam logic [2:0] DEV2 = 3'h6;
  logic       clk, rst_n, gate, lv, scl, sda_h, oe, osc, ok, oe2, osc2;
  logic [7:0] pout, pout2, rd;
  logic [2:0] dv;
  int         error_cnt, checked, cyc;
  wire logic  sda;
  topc_row_s  rows [8] = '{'{CMD_LEVEL, 8'h5A, 8'h5A},
    '{CMD_SCALE, 8'hA5, 8'hA5}, '{CMD_PDLY0, 8'h01, 8'h01},
    '{4'h9, 8'h04, 8'h04}, '{4'hA, 8'h40, 8'h40},
    '{CMD_PDLY3, 8'h80, 8'h80}, '{CMD_TSTART, 8'h00, 8'hFF},
    '{4'h3, 8'h12, 8'h00}};
  logic [7:0] dl [4] = '{8'h01, 8'h04, 8'h00, 8'h00};

  assign sda = sda_h & ~oe & ~oe2;

  topc_controller #(.DEV_CODE(DEV)) u_dut (
    .core_clk_i(clk), .arst_n_i(rst_n), .scl_clk_i(scl), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(oe), .start_gate_pin_i(gate),
    .ext_clk_i(1'b0), .low_volt_i(lv), .port_out_o(pout),
    .osc_run_o(osc));
  // Second unit: start option 2, option B units from an external clock
  topc_controller #(.DEV_CODE(DEV2), .START_OPTION(2), .OPTION_B(1'b1),
    .EXT_CLOCK(1'b1)) u_dut2 (
    .core_clk_i(clk), .arst_n_i(rst_n), .scl_clk_i(scl), .scl_i(scl),
    .sda_i(sda), .sda_o(), .sda_oe_o(oe2), .start_gate_pin_i(gate),
    .ext_clk_i(cyc[2]), .low_volt_i(lv), .port_out_o(pout2),
    .osc_run_o(osc2));
  topc_host_model u_host (
    .core_clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic one(input logic [3:0] c, input logic rw);
    u_host.frame({dv, c, rw}, 8'hFF, 1, rd, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic wr(input logic [3:0] c, input logic [7:0] d);
    u_host.frame({dv, c, 1'b0}, d, 2, rd, ok);
    chk({7'h00, ok}, 8'h01);
  endtask

  task automatic rdc(input logic [3:0] c, input logic [7:0] e);
    u_host.frame({dv, c, 1'b1}, 8'hFF, 2, rd, ok);
    chk(rd, e);
  endtask

  task automatic wt(input logic [7:0] m, input logic [7:0] v, input int n);
    int k;
    k = 0;
    while ((pout & m) !== v && k < n) begin
      @(posedge clk);
      k++;
    end
    chk(pout & m, v);
  endtask

  task automatic summarize;
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    rst_n = 1'b0;
    gate = 1'b0;
    lv = 1'b0;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    dv = DEV;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    chk({pout[7:1], osc}, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].c, rows[i].d);
      rdc(rows[i].c, rows[i].e);
    end
    chk(pout, 8'h5A);
    u_host.frame({~DEV, CMD_LEVEL, 1'b0}, 8'h00, 2, rd, ok);
    chk({7'h00, ok}, 8'h00);
    chk(pout, 8'h5A);
    one(CMD_ACCESS, 1'b1);
    wr(CMD_LEVEL, 8'h3C);
    one(CMD_ACCESS, 1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(CMD_LEVEL, 8'hC3);
      one(CMD_ACCESS, 1'b1);
      rdc(CMD_LEVEL, 8'h3C);
      one(CMD_ACCESS, 1'b0);
      rdc(CMD_LEVEL, 8'hC3);
      one(CMD_RELOAD, 1'(i));
      wt(8'hFF, 8'h3C, 20);
    end
    wr(CMD_LEVEL, 8'h00);
    wr(CMD_SCALE, 8'h0D);
    foreach (dl[i]) begin
      wr(4'(8 + i), dl[i]);
    end
    gate <= 1'b1;
    repeat (40) @(posedge clk);
    chk({pout[7:1], osc}, 8'h01);
    wt(8'hFF, 8'h01, 40);
    gate <= 1'b0;
    one(CMD_RELOAD, 1'b0);
    wr(CMD_TSTART, 8'h0F);
    wt(8'h02, 8'h02, 10000);
    repeat (4) @(posedge clk);
    chk(pout, 8'h03);
    chk({7'h00, osc}, 8'h00);
    rdc(CMD_LEVEL, 8'h00);
    wr(4'h9, 8'h00);
    gate <= 1'b1;
    wt(8'hFF, 8'h02, 100);
    wr(CMD_TSTART, 8'h01);
    wt(8'hFF, 8'h03, 100);
    rdc(CMD_TSTART, 8'hFF);
    wr(CMD_LEVEL, 8'h81);
    lv <= 1'b1;
    wt(8'hFF, 8'h00, 10);
    lv <= 1'b0;
    wt(8'hFF, 8'h3C, 20);
    repeat (20) @(posedge clk);
    chk({7'h00, osc}, 8'h00);
    dv = DEV2;
    one(CMD_ACCESS, 1'b1);
    wr(CMD_PDLY0, 8'h01);
    gate <= 1'b0;
    repeat (10) @(posedge clk);
    gate <= 1'b1;
    one(CMD_RELOAD, 1'b0);
    chk({7'h00, osc2}, 8'h00);
    chk(pout2, 8'h00);
    wr(CMD_TSTART, 8'h01);
    repeat (900) @(posedge clk);
    chk({7'h00, osc2}, 8'h01);
    chk(pout2, 8'h00);
    repeat (200) @(posedge clk);
    chk(pout2, 8'h01);
    chk({7'h00, osc2}, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire
